// ==== inc/i2c_stat_pkg.sv ====
// constants and carrier types for the i2c raw interrupt status block
package i2c_stat_pkg;

    // register byte addresses on the peripheral bus
    localparam logic [31:0] RAW_STAT_ADDR = 32'h5002_0334;
    localparam logic [31:0] CLR_INTR_ADDR = 32'h5002_0340;
    localparam logic [31:0] CLR_RD_REQ_ADDR = 32'h5002_0350;
    localparam logic [31:0] CLR_TRANSMIT_ABORT_FLAG_ADDR = 32'h5002_0354;
    localparam logic [31:0] CLR_ACTIVITY_ADDR = 32'h5002_035c;
    localparam logic [31:0] CLR_GENERAL_CALL_SEEN_ADDR = 32'h5002_0368;
    localparam logic [31:0] ABORT_CAUSE_ADDR = 32'h5002_0380;

    // status field layout
    localparam int unsigned STAT_W = 15;
    localparam int unsigned B_STUCK_LOW = 14;
    localparam int unsigned B_MASTER_HOLD = 13;
    localparam int unsigned B_RESTART = 12;
    localparam int unsigned B_GENERAL_CALL_SEEN = 11;
    localparam int unsigned B_START = 10;
    localparam int unsigned B_STOP = 9;
    localparam int unsigned B_ACTIVITY = 8;
    localparam int unsigned B_SLV_TX_DONE = 7;
    localparam int unsigned B_TX_ABORT = 6;
    localparam int unsigned B_RD_REQ = 5;
    localparam int unsigned B_CLR_FLAG = 0;

    // reset values
    localparam logic [STAT_W-1:0] STAT_RESET = 15'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic STUCK_LOW_RESET = 1'h0;

    localparam int unsigned ABORT_CAUSE_W = 16;
    localparam logic [ABORT_CAUSE_W-1:0] ABORT_CAUSE_RESET = 16'h0000;

    // peripheral bus request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    // static configuration bits from the controller's setup registers
    typedef struct packed {
        logic dynamic_target_update;
        logic empty_fifo_master_hold_enable;
        logic slave_repeated_start_detect_enable;
    } stat_cfg_s;

    // state and event strobes from the controller engine, same clock
    typedef struct packed {
        logic enable;
        logic master_mode;
        logic slave_mode;
        logic bus_held;
        logic tx_fifo_empty;
        logic slave_addressed;
        logic repeated_start;
        logic high_speed_mode;
        logic start_byte_xfer;
        logic general_call_acked;
        logic slave_tx_nack;
        logic tx_abort;
        logic [ABORT_CAUSE_W-1:0] abort_cause;
        logic read_request;
        logic engine_busy;
    } ctrl_evt_s;

endpackage : i2c_stat_pkg

// ==== core/sticky_flags.sv ====
// bank of sticky flags where a set beats a simultaneous clear
`timescale 1ns/1ps
module sticky_flags
    import i2c_stat_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flags_o
);

    typedef struct packed {
        logic [W-1:0] flags;
    } sticky_state_s;

    sticky_state_s state;
    sticky_state_s next_state;

    // set wins so an event landing on the clearing read is not lost
    always_comb begin
        next_state.flags = (state.flags & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state.flags <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign flags_o = state.flags;

endmodule : sticky_flags

// ==== core/bus_condition_detect.sv ====
// start and stop detection on the synchronised serial pins
`timescale 1ns/1ps
module bus_condition_detect
    import i2c_stat_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic start_o,
    output logic stop_o,
    output logic busy_o
);

    typedef struct packed {
        logic scl_meta;
        logic sda_meta;
        logic scl_sync;
        logic sda_sync;
        logic scl_prev;
        logic sda_prev;
        logic start;
        logic stop;
        logic busy;
    } detect_state_s;

    detect_state_s state;
    detect_state_s next_state;

    // meta stage feeds only the sync stage; edges look at sync and prev
    always_comb begin
        next_state = state;
        next_state.scl_meta = scl_i;
        next_state.sda_meta = sda_i;
        next_state.scl_sync = state.scl_meta;
        next_state.sda_sync = state.sda_meta;
        next_state.scl_prev = state.scl_sync;
        next_state.sda_prev = state.sda_sync;
        // data falls while clock stays high: start or repeated start
        next_state.start = state.scl_sync & state.scl_prev & state.sda_prev & ~state.sda_sync;
        // data rises while clock stays high: stop
        next_state.stop = state.scl_sync & state.scl_prev & ~state.sda_prev & state.sda_sync;
        if (next_state.start) begin
            next_state.busy = 1'b1;
        end else if (next_state.stop) begin
            next_state.busy = 1'b0;
        end
    end

    // pins idle high, so the sync chain resets to one to avoid a false edge
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= '{scl_meta: 1'b1, sda_meta: 1'b1, scl_sync: 1'b1, sda_sync: 1'b1,
                       scl_prev: 1'b1, sda_prev: 1'b1, start: 1'b0, stop: 1'b0,
                       busy: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign start_o = state.start;
    assign stop_o = state.stop;
    assign busy_o = state.busy;

endmodule : bus_condition_detect

// ==== core/i2c_raw_interrupt_status.sv ====
// raw interrupt status flags of the i2c controller with their clear registers
`timescale 1ns/1ps
module i2c_raw_interrupt_status
    import i2c_stat_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire apb_req_s apb_req_i,
    input wire stat_cfg_s cfg_i,
    input wire ctrl_evt_s ctrl_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output apb_rsp_s apb_rsp_o,
    output logic tx_fifo_flush_o,
    output logic clock_stretch_o
);

    typedef struct packed {
        apb_rsp_s rsp;
        logic master_hold;
        logic [ABORT_CAUSE_W-1:0] abort_cause;
        logic tx_flush;
        logic stretch;
    } stat_state_s;

    stat_state_s state;
    stat_state_s next_state;

    logic bus_start;
    logic bus_stop;
    logic bus_busy;
    logic [STAT_W-1:0] flag_set;
    logic [STAT_W-1:0] flag_clr;
    logic [STAT_W-1:0] flags;
    logic [STAT_W-1:0] raw_status;
    logic rd_done;
    logic clr_all_rd;
    logic clr_rd_req_rd;
    logic clr_abort_rd;
    logic clr_activity_rd;
    logic clr_general_call_seen_rd;
    logic restart_ok;

    // serial side start and stop seen by this block itself
    bus_condition_detect u_detect (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .start_o(bus_start),
        .stop_o(bus_stop),
        .busy_o(bus_busy)
    );

    // the sticky event flags of the raw status word
    sticky_flags #(
        .W(STAT_W)
    ) u_flags (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .flags_o(flags)
    );

    // a read finishes on the access cycle where our registered ready is high
    assign rd_done = apb_req_i.psel & apb_req_i.penable & state.rsp.pready & ~apb_req_i.pwrite;
    assign clr_all_rd = rd_done & (apb_req_i.paddr == CLR_INTR_ADDR);
    assign clr_rd_req_rd = rd_done & (apb_req_i.paddr == CLR_RD_REQ_ADDR);
    assign clr_abort_rd = rd_done & (apb_req_i.paddr == CLR_TRANSMIT_ABORT_FLAG_ADDR);
    assign clr_activity_rd = rd_done & (apb_req_i.paddr == CLR_ACTIVITY_ADDR);
    assign clr_general_call_seen_rd = rd_done & (apb_req_i.paddr == CLR_GENERAL_CALL_SEEN_ADDR);

    // restart precedes the address in these modes so nobody is addressed yet
    assign restart_ok = ~ctrl_i.high_speed_mode & ~ctrl_i.start_byte_xfer;

    // event sources into the sticky bank
    always_comb begin
        flag_set = STAT_RESET;
        flag_clr = STAT_RESET;
        flag_set[B_RESTART] = cfg_i.slave_repeated_start_detect_enable & ctrl_i.slave_mode
                            & ctrl_i.slave_addressed & ctrl_i.repeated_start
                            & restart_ok;
        flag_set[B_GENERAL_CALL_SEEN] = ctrl_i.general_call_acked;
        flag_set[B_START] = bus_start;
        flag_set[B_STOP] = bus_stop;
        flag_set[B_ACTIVITY] = ctrl_i.enable & (ctrl_i.engine_busy | bus_busy);
        flag_set[B_SLV_TX_DONE] = ctrl_i.slave_mode & ctrl_i.slave_tx_nack;
        flag_set[B_TX_ABORT] = ctrl_i.tx_abort;
        flag_set[B_RD_REQ] = ctrl_i.slave_mode & ctrl_i.read_request;
        // clears; the combined clear read sweeps every event flag
        flag_clr[B_RESTART] = clr_all_rd;
        flag_clr[B_GENERAL_CALL_SEEN] = ~ctrl_i.enable | clr_general_call_seen_rd | clr_all_rd;
        flag_clr[B_START] = clr_all_rd;
        flag_clr[B_STOP] = clr_all_rd;
        flag_clr[B_ACTIVITY] = ~ctrl_i.enable | clr_activity_rd | clr_all_rd;
        flag_clr[B_SLV_TX_DONE] = clr_all_rd;
        flag_clr[B_TX_ABORT] = clr_abort_rd | clr_all_rd;
        flag_clr[B_RD_REQ] = clr_rd_req_rd | clr_all_rd;
    end

    // assembled status word; stuck low stays at its reset value
    always_comb begin
        raw_status = flags;
        raw_status[B_MASTER_HOLD] = state.master_hold;
        raw_status[B_STUCK_LOW] = STUCK_LOW_RESET;
    end

    // next state: bus answer, hold level, abort cause, side outputs
    always_comb begin
        next_state = state;
        // master hold is a live level, not sticky, gated by both enables
        next_state.master_hold = cfg_i.dynamic_target_update
                               & cfg_i.empty_fifo_master_hold_enable
                               & ctrl_i.master_mode & ctrl_i.bus_held
                               & ctrl_i.tx_fifo_empty;
        // cause captured on the rising abort, dropped when the flag goes
        if (ctrl_i.tx_abort & ~flags[B_TX_ABORT]) begin
            next_state.abort_cause = ctrl_i.abort_cause;
        end else if (~flags[B_TX_ABORT]) begin
            next_state.abort_cause = ABORT_CAUSE_RESET;
        end
        // the flops take the flag's next value, so flush and stretch track
        // the flag with no lag and still come straight from flops
        next_state.tx_flush = (flags[B_TX_ABORT] & ~flag_clr[B_TX_ABORT])
                            | flag_set[B_TX_ABORT];
        next_state.stretch = (flags[B_RD_REQ] & ~flag_clr[B_RD_REQ])
                           | flag_set[B_RD_REQ];
        // no wait state: ready rises in the first access cycle
        next_state.rsp.pready = apb_req_i.psel & ~apb_req_i.penable;
        next_state.rsp.pslverr = 1'b0;
        next_state.rsp.prdata = WORD_ZERO;
        if (apb_req_i.psel & ~apb_req_i.penable) begin
            case (apb_req_i.paddr)
                RAW_STAT_ADDR: begin
                    // upper bits stay zero; writes here change nothing
                    next_state.rsp.prdata[STAT_W-1:0] = apb_req_i.pwrite ? STAT_RESET
                                                                        : raw_status;
                end
                CLR_INTR_ADDR: begin
                    next_state.rsp.prdata[B_CLR_FLAG] = ~apb_req_i.pwrite & (|flags);
                end
                CLR_RD_REQ_ADDR: begin
                    next_state.rsp.prdata[B_CLR_FLAG] = ~apb_req_i.pwrite & flags[B_RD_REQ];
                end
                CLR_TRANSMIT_ABORT_FLAG_ADDR: begin
                    next_state.rsp.prdata[B_CLR_FLAG] = ~apb_req_i.pwrite & flags[B_TX_ABORT];
                end
                CLR_ACTIVITY_ADDR: begin
                    next_state.rsp.prdata[B_CLR_FLAG] = ~apb_req_i.pwrite & flags[B_ACTIVITY];
                end
                CLR_GENERAL_CALL_SEEN_ADDR: begin
                    next_state.rsp.prdata[B_CLR_FLAG] = ~apb_req_i.pwrite & flags[B_GENERAL_CALL_SEEN];
                end
                ABORT_CAUSE_ADDR: begin
                    next_state.rsp.prdata[ABORT_CAUSE_W-1:0] = apb_req_i.pwrite
                                                              ? ABORT_CAUSE_RESET
                                                              : state.abort_cause;
                end
                default: begin
                    // unmapped address answers with an error, data zero
                    next_state.rsp.pslverr = 1'b1;
                end
            endcase
        end
    end

    // every field returns to a quiet value under reset
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state.rsp.pready <= 1'b0;
            state.rsp.pslverr <= 1'b0;
            state.rsp.prdata <= WORD_ZERO;
            state.master_hold <= 1'b0;
            state.abort_cause <= ABORT_CAUSE_RESET;
            state.tx_flush <= 1'b0;
            state.stretch <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign apb_rsp_o = state.rsp;
    assign tx_fifo_flush_o = state.tx_flush;
    assign clock_stretch_o = state.stretch;

endmodule : i2c_raw_interrupt_status

// ==== tb/i2c_stat_props.sv ====
// port-level assertions for the raw interrupt status block
`timescale 1ns/1ps
module i2c_stat_props
    import i2c_stat_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire apb_req_s apb_req_i,
    input wire stat_cfg_s cfg_i,
    input wire ctrl_evt_s ctrl_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire apb_rsp_s apb_rsp_o,
    input wire logic tx_fifo_flush_o,
    input wire logic clock_stretch_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic rd_done;
    logic abrt_rd;
    logic rdq_rd;
    // edge at which clear-on-read side effects land
    assign rd_done = apb_req_i.psel && apb_req_i.penable && !apb_req_i.pwrite && apb_rsp_o.pready;
    // the combined clear may also release, so the hold checks accept it
    assign abrt_rd = rd_done
                     && (apb_req_i.paddr == CLR_TRANSMIT_ABORT_FLAG_ADDR || apb_req_i.paddr == CLR_INTR_ADDR);
    assign rdq_rd = rd_done
                    && (apb_req_i.paddr == CLR_RD_REQ_ADDR || apb_req_i.paddr == CLR_INTR_ADDR);
    a_pready_after_setup: assert property (
        apb_req_i.psel && !apb_req_i.penable |=> apb_rsp_o.pready)
        else $error("no answer one cycle after setup");
    a_pready_one_cycle: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
        else $error("answer held longer than one cycle");
    a_status_upper_zero: assert property (
        apb_rsp_o.pready && apb_req_i.paddr == RAW_STAT_ADDR |-> apb_rsp_o.prdata[31:14] == 18'h0)
        else $error("reserved status bits not zero");
    a_write_reads_zero: assert property (
        apb_rsp_o.pready && apb_req_i.pwrite |-> apb_rsp_o.prdata == 32'h0)
        else $error("write returned data");
    a_flush_on_abort: assert property (ctrl_i.tx_abort |=> tx_fifo_flush_o)
        else $error("abort did not flush the transmit fifo");
    a_flush_hold: assert property (
        tx_fifo_flush_o && !abrt_rd && !$past(abrt_rd) |=> tx_fifo_flush_o)
        else $error("flush dropped without a clear read");
    a_flush_release: assert property (
        rd_done && apb_req_i.paddr == CLR_TRANSMIT_ABORT_FLAG_ADDR && !ctrl_i.tx_abort ##1 !ctrl_i.tx_abort
        |=> !tx_fifo_flush_o) else $error("flush kept after abort clear read");
    a_stretch_on_req: assert property (
        ctrl_i.read_request && ctrl_i.slave_mode |=> clock_stretch_o)
        else $error("read request did not stretch the clock");
    a_stretch_hold: assert property (
        clock_stretch_o && !rdq_rd && !$past(rdq_rd) |=> clock_stretch_o)
        else $error("stretch dropped without a clear read");
    a_stretch_release: assert property (
        rd_done && apb_req_i.paddr == CLR_RD_REQ_ADDR && !ctrl_i.read_request
        ##1 !ctrl_i.read_request |=> !clock_stretch_o)
        else $error("stretch kept after read request clear");
endmodule : i2c_stat_props

bind i2c_raw_interrupt_status i2c_stat_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .apb_req_i(apb_req_i), .cfg_i(cfg_i), .ctrl_i(ctrl_i), .scl_i(scl_i), .sda_i(sda_i),
    .apb_rsp_o(apb_rsp_o), .tx_fifo_flush_o(tx_fifo_flush_o), .clock_stretch_o(clock_stretch_o));

// ==== tb/i2c_bus_model.sv ====
// far-side bus party that makes start and stop conditions on the pins
`timescale 1ns/1ps
module i2c_bus_model (
    input wire logic clk_i,
    output logic scl_o,
    output logic sda_o
);
    // released lines sit high through the pull-ups
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // start: data falls while clock high, then clock goes low
    task automatic start_cond();
        @(posedge clk_i);
        sda_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        scl_o <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : start_cond
    // stop: data rises while clock high; idle gap lets the synchroniser catch up
    task automatic stop_cond();
        repeat (2) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sda_o <= 1'b1;
        repeat (6) @(posedge clk_i);
    endtask : stop_cond
endmodule : i2c_bus_model

// ==== tb/tb.sv ====
// self-checking bench for the raw interrupt status block
`timescale 1ns/1ps
module tb
    import i2c_stat_pkg::*;
;
    typedef struct packed {
        logic [7:0] k;
        logic [2:0] g;
        logic en;
        logic [14:0] e;
    } row_s;
    // k: hold, restart, high speed, start byte, addressed, general_call_seen, nack, busy
    localparam row_s ROWS [12] = '{
        '{8'h01, 3'h7, 1'b1, 15'h2000}, '{8'h01, 3'h3, 1'b1, 15'h0},
        '{8'h01, 3'h5, 1'b1, 15'h0}, '{8'h12, 3'h7, 1'b1, 15'h1000},
        '{8'h12, 3'h6, 1'b1, 15'h0}, '{8'h16, 3'h7, 1'b1, 15'h0},
        '{8'h1a, 3'h7, 1'b1, 15'h0}, '{8'h02, 3'h7, 1'b1, 15'h0},
        '{8'h20, 3'h7, 1'b1, 15'h0800}, '{8'h42, 3'h7, 1'b1, 15'h0080},
        '{8'h80, 3'h7, 1'b1, 15'h0100}, '{8'h80, 3'h7, 1'b0, 15'h0}};
    logic clk_i = 1'b0;
    logic rst_n_i;
    apb_req_s apb_req_i;
    stat_cfg_s cfg_i;
    ctrl_evt_s ctrl_i;
    apb_rsp_s apb_rsp_o;
    logic tx_fifo_flush_o;
    logic clock_stretch_o;
    logic scl_o;
    logic sda_o;
    wire scl = scl_o & ~clock_stretch_o; // stretch pulls the open-drain clock low
    int errors;
    int n_tests;
    logic [31:0] d;
    logic e;
    ctrl_evt_s c;
    always #5 clk_i = ~clk_i;
    i2c_raw_interrupt_status uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i),
        .cfg_i(cfg_i), .ctrl_i(ctrl_i), .scl_i(scl), .sda_i(sda_o), .apb_rsp_o(apb_rsp_o),
        .tx_fifo_flush_o(tx_fifo_flush_o), .clock_stretch_o(clock_stretch_o));
    i2c_bus_model bus (.clk_i(clk_i), .scl_o(scl_o), .sda_o(sda_o));
    // engine strobes from a row code
    function automatic ctrl_evt_s mk(input logic [7:0] k, input logic en);
        ctrl_evt_s r;
        r = '0;
        r.enable = en;
        r.master_mode = k[0];
        r.bus_held = k[0];
        r.tx_fifo_empty = k[0];
        r.repeated_start = k[1];
        r.slave_mode = k[1];
        r.high_speed_mode = k[2];
        r.start_byte_xfer = k[3];
        r.slave_addressed = k[4];
        r.general_call_acked = k[5];
        r.slave_tx_nack = k[6];
        r.engine_busy = k[7];
        return r;
    endfunction : mk
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one bus cycle; answer taken and request released at the rising edge that sees ready
    task automatic apb(input logic w, input logic [31:0] a,
        output logic [31:0] rd, output logic er);
        int i;
        @(posedge clk_i);
        apb_req_i <= '{1'b1, 1'b0, w, a, {32{w}}};
        @(posedge clk_i);
        apb_req_i.penable <= 1'b1;
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            if (apb_rsp_o.pready === 1'b1) break;
        end
        if (i == 4) begin
            errors++;
            print_verdict();
        end
        rd = apb_rsp_o.prdata;
        er = apb_rsp_o.pslverr;
        apb_req_i <= '0;
    endtask : apb
    task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x,
        input string nm);
        apb(1'b0, a, d, e);
        chk(nm, d & m, x);
    endtask : rdc
    initial begin
        errors = 0;
        n_tests = 0;
        rst_n_i = 1'b0;
        apb_req_i = '0;
        cfg_i = 3'h7;
        ctrl_i = mk(8'h00, 1'b1);
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(RAW_STAT_ADDR, 32'hffffffff, 32'h0, "reset status");
        rdc(ABORT_CAUSE_ADDR, 32'hffffffff, 32'h0, "reset cause");
        // bit 10 masked: whether an engine restart strobe also marks start is left open
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            cfg_i <= ROWS[i].g;
            ctrl_i <= mk(ROWS[i].k, ROWS[i].en);
            rdc(RAW_STAT_ADDR, 32'h7bff, {17'h0, ROWS[i].e}, "row");
            ctrl_i <= mk(8'h00, 1'b1);
            apb(1'b0, CLR_INTR_ADDR, d, e);
        end
        bus.start_cond();
        rdc(RAW_STAT_ADDR, 32'h0400, 32'h0400, "pin start");
        bus.stop_cond();
        rdc(RAW_STAT_ADDR, 32'h0700, 32'h0700, "pin stop");
        rdc(CLR_ACTIVITY_ADDR, 32'h1, 32'h1, "activity clear");
        rdc(RAW_STAT_ADDR, 32'h0100, 32'h0, "activity gone");
        rdc(CLR_INTR_ADDR, 32'h1, 32'h1, "combined clear");
        // sticky pair, own clear, then disable
        @(posedge clk_i);
        ctrl_i <= mk(8'ha0, 1'b1);
        @(posedge clk_i);
        ctrl_i <= mk(8'h00, 1'b1);
        rdc(RAW_STAT_ADDR, 32'h7fff, 32'h0900, "sticky pair");
        rdc(CLR_GENERAL_CALL_SEEN_ADDR, 32'h1, 32'h1, "general_call_seen clear");
        rdc(RAW_STAT_ADDR, 32'h7fff, 32'h0100, "general_call_seen gone");
        ctrl_i <= mk(8'h20, 1'b1);
        @(posedge clk_i);
        ctrl_i <= mk(8'h00, 1'b0);
        @(posedge clk_i);
        ctrl_i <= mk(8'h00, 1'b1);
        rdc(RAW_STAT_ADDR, 32'h7fff, 32'h0, "disable clears");
        // abort with a wide cause, write refused, flush held until the clear lands
        c = mk(8'h00, 1'b1);
        c.tx_abort = 1'b1;
        c.abort_cause = 16'hc0a5;
        ctrl_i <= c;
        @(posedge clk_i);
        ctrl_i <= mk(8'h00, 1'b1);
        @(negedge clk_i);
        chk("flush set", {31'h0, tx_fifo_flush_o}, 32'h1);
        apb(1'b1, RAW_STAT_ADDR, d, e);
        chk("write refused", d | {31'h0, e}, 32'h0);
        rdc(RAW_STAT_ADDR, 32'hffffffff, 32'h0040, "abort flag");
        rdc(ABORT_CAUSE_ADDR, 32'hffff, 32'hc0a5, "abort cause");
        @(negedge clk_i);
        chk("flush held", {31'h0, tx_fifo_flush_o}, 32'h1);
        rdc(CLR_TRANSMIT_ABORT_FLAG_ADDR, 32'h1, 32'h1, "abort clear");
        @(negedge clk_i);
        chk("flush off", {31'h0, tx_fifo_flush_o}, 32'h0);
        rdc(ABORT_CAUSE_ADDR, 32'hffff, 32'h0, "cause dropped");
        // read request stretches the clock until its clear
        c = mk(8'h00, 1'b1);
        c.slave_mode = 1'b1;
        c.read_request = 1'b1;
        ctrl_i <= c;
        @(posedge clk_i);
        ctrl_i <= mk(8'h00, 1'b1);
        @(negedge clk_i);
        chk("clock held low", {31'h0, scl}, 32'h0);
        rdc(CLR_RD_REQ_ADDR, 32'h1, 32'h1, "read request clear");
        repeat (2) @(negedge clk_i);
        chk("stretch off", {31'h0, clock_stretch_o}, 32'h0);
        apb(1'b0, 32'h5002_03f0, d, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        // reset in mid-run drops sticky flags
        ctrl_i <= mk(8'ha0, 1'b1);
        @(posedge clk_i);
        ctrl_i <= mk(8'h00, 1'b1);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdc(RAW_STAT_ADDR, 32'h7fff, 32'h0, "reset clears");
        print_verdict();
    end
endmodule : tb
